// ==== include/nib_adapt_pkg.sv ====
/*
 * package for the odd nibble transmit adapter: carrier structs, run kinds
 * and the fixed octet codes.
 * assumes one nibble per clock from the mac, low nibble of an octet first.
 */
package nib_adapt_pkg;

	// ************************************************************
	// run kinds and carriers
	// ************************************************************
	typedef enum logic [1:0] {K_IDLE, K_DATA, K_EXT} kind_e;

	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] d;
	} nib_s;

	typedef struct packed {
		logic en;
		logic er;
		logic [7:0] data;
	} oct_s;

	// ************************************************************
	// octet codes and counts
	// ************************************************************
	localparam logic [7:0] EXT_DATA = 8'h0F;
	localparam logic [7:0] EXT_ERR_DATA = 8'h1F;
	localparam logic [7:0] IDLE_DATA = 8'h00;
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam int MIN_GAP_NIB = 3;
	localparam oct_s OCT_RESET = '{en: 1'b0, er: 1'b0, data: 8'h00};

endpackage : nib_adapt_pkg

// ==== verilog/nib_classify.sv ====
/*
 * sorts one mac nibble into idle, data or carrier extension.
 * assumes the mac marks extension with enable low and error high.
 */
`timescale 1ns/100ps
`default_nettype none

module nib_classify
	import nib_adapt_pkg::*;
(
	// nibble in
	input wire nib_s i_nib,
	// kind out
	output var kind_e o_kind
);

	// ************************************************************
	// classification
	// ************************************************************
	always_comb begin
		if (i_nib.en) begin
			o_kind = K_DATA;
		end else if (i_nib.er) begin
			o_kind = K_EXT;
		end else begin
			o_kind = K_IDLE;
		end
	end

endmodule : nib_classify

`default_nettype wire

// ==== verilog/sgmii_odd_nibble_tx_adapt.sv ====
/*
 * transmit rate adapter: pairs mac nibbles into pcs octets and settles
 * every odd-length frame, extension and interframe gap at its end.
 * assumes one nibble per i_clock and a pcs encoder that takes o_oct
 * whenever o_valid pulses; o_oct stands until the next pulse.
 */
`timescale 1ns/100ps
`default_nettype none

module sgmii_odd_nibble_tx_adapt
	import nib_adapt_pkg::*;
#(
	parameter int GAP_CNT_W = 8
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// mac nibble side
	input wire nib_s i_nib,
	// pcs octet side
	output logic o_valid,
	output var oct_s o_oct,
	// status
	output logic o_gap_short
);

	// ************************************************************
	// parameter check
	// ************************************************************
	generate
		if (GAP_CNT_W < 3) begin : g_bad_width
			$error("GAP_CNT_W must be at least 3");
		end
	endgenerate

	// ************************************************************
	// classification
	// ************************************************************
	kind_e kind;
	kind_e held_kind;
	kind_e last_kind;
	logic held;
	nib_s held_nib;
	logic seen_frame;
	logic [GAP_CNT_W-1:0] gap_nib;
	logic [GAP_CNT_W-1:0] eff_gap;
	logic next_valid;
	oct_s next_oct;
	logic same_run;
	logic gap_end;

	nib_classify u_classify (
		.i_nib(i_nib),
		.o_kind(kind)
	);

	assign same_run = held && (kind == held_kind);
	assign eff_gap = {gap_nib[GAP_CNT_W-1:1], 1'b0};
	assign gap_end = (last_kind == K_IDLE) && (kind == K_DATA);

	// ************************************************************
	// pairing and odd-end resolution
	// ************************************************************
	always_comb begin
		next_valid = 1'b0;
		next_oct = o_oct;
		if (same_run) begin
			next_valid = 1'b1;
			case (held_kind)
				K_DATA: begin
					next_oct.en = 1'b1;
					next_oct.er = held_nib.er | i_nib.er;
					next_oct.data = {i_nib.d, held_nib.d};
				end
				K_EXT: begin
					next_oct.en = 1'b0;
					next_oct.er = 1'b1;
					next_oct.data = EXT_DATA;
				end
				default: begin
					next_oct.en = 1'b0;
					next_oct.er = 1'b0;
					next_oct.data = IDLE_DATA;
				end
			endcase
		end else if (held && held_kind == K_EXT) begin
			next_valid = 1'b1;
			next_oct.en = 1'b0;
			next_oct.er = 1'b1;
			next_oct.data = EXT_ERR_DATA;
		end
	end

	// ************************************************************
	// parity state
	// ************************************************************
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			held <= 1'b0;
			held_kind <= K_IDLE;
			held_nib <= '{en: 1'b0, er: 1'b0, d: NIB_RESET};
		end else begin
			// a lone data or idle nibble at a run change is dropped
			held <= !same_run;
			held_kind <= kind;
			held_nib <= i_nib;
		end
	end

	// ************************************************************
	// octet output
	// ************************************************************
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_oct <= OCT_RESET;
		end else begin
			o_valid <= next_valid;
			o_oct <= next_oct;
		end
	end

	// ************************************************************
	// interframe gap watch
	// ************************************************************
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			last_kind <= K_IDLE;
			seen_frame <= 1'b0;
			gap_nib <= '0;
		end else begin
			last_kind <= kind;
			if (kind == K_DATA) begin
				seen_frame <= 1'b1;
			end
			if (kind != K_IDLE) begin
				gap_nib <= '0;
			end else if (gap_nib != '1) begin
				gap_nib <= gap_nib + GAP_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_gap_short <= 1'b0;
		end else begin
			o_gap_short <= gap_end && seen_frame &&
				(eff_gap < GAP_CNT_W'(MIN_GAP_NIB));
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_lone_data_end;
		held && held_kind == K_DATA && kind != K_DATA;
	endsequence

	sequence s_lone_ext_end;
		held && held_kind == K_EXT && kind != K_EXT;
	endsequence

	sequence s_ext_then_data;
		s_lone_ext_end ##0 kind == K_DATA ##1 kind == K_DATA;
	endsequence

	chk_lone_data_drop: assert property (@(posedge i_clock) disable iff (i_rst)
		s_lone_data_end |=> !o_valid)
		else $error("lone data nibble was not dropped");

	chk_ext_stuff: assert property (@(posedge i_clock) disable iff (i_rst)
		s_lone_ext_end |=> o_valid && !o_oct.en && o_oct.er)
		else $error("odd extension was not stuffed");

	chk_stuff_code: assert property (@(posedge i_clock) disable iff (i_rst)
		s_lone_ext_end |=> o_oct.data == EXT_ERR_DATA)
		else $error("stuffed extension not sent as error code");

	chk_ext_octet: assert property (@(posedge i_clock) disable iff (i_rst)
		held && held_kind == K_EXT && kind == K_EXT
		|=> o_valid && o_oct.data == EXT_DATA && !o_oct.en)
		else $error("extension pair not sent as extension");

	chk_err_octet: assert property (@(posedge i_clock) disable iff (i_rst)
		held && held_kind == K_DATA && kind == K_DATA
		&& (held_nib.er || i_nib.er) |=> o_oct.er && o_oct.en)
		else $error("nibble error not spread over its octet");

	chk_frame_after: assert property (@(posedge i_clock) disable iff (i_rst)
		s_ext_then_data |=> o_valid && o_oct.en)
		else $error("frame after short extension was lost");

	chk_gap_short: assert property (@(posedge i_clock) disable iff (i_rst)
		o_gap_short |-> $past(gap_end) && $past(eff_gap) < MIN_GAP_NIB
		&& $past(seen_frame))
		else $error("gap short flag without a short gap");

	chk_pair_emit: assert property (@(posedge i_clock) disable iff (i_rst)
		same_run |=> o_valid ##1 (!o_valid || !$past(same_run, 2)))
		else $error("nibble pair did not yield one octet");

	sequence s_short_gap;
		kind == K_DATA ##1 kind == K_IDLE [*3] ##1 kind == K_DATA;
	endsequence

	sequence s_long_gap;
		kind == K_DATA ##1 kind == K_IDLE [*4] ##1 kind == K_DATA;
	endsequence

	chk_gap_flag: assert property (@(posedge i_clock) disable iff (i_rst)
		s_short_gap |=> o_gap_short)
		else $error("three nibble gap was not flagged");

	chk_gap_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		s_long_gap |=> !o_gap_short)
		else $error("four nibble gap was flagged as short");

	chk_idle_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
		held && held_kind == K_IDLE && kind == K_IDLE
		|=> o_valid && !o_oct.en && !o_oct.er)
		else $error("idle pair carried a payload");

endmodule : sgmii_odd_nibble_tx_adapt

`default_nettype wire

// ==== test/mac_nib_model.sv ====
/* mac model: drives one nibble per clock.
   assumes the bench calls put once per cycle. */
`timescale 1ns/100ps
`default_nettype none
module mac_nib_model
	import nib_adapt_pkg::*;
(
	// clock in, nibble out
	input wire logic i_clock,
	output var nib_s o_nib
);
	// ********************
	// nibble driver
	// ********************
	initial o_nib = '0;
	task automatic put(input logic en, input logic er, input logic [3:0] d);
		@(posedge i_clock);
		#1 o_nib = '{en: en, er: er, d: d};
	endtask : put
endmodule : mac_nib_model
`default_nettype wire

// ==== test/sgmii_odd_nibble_tx_adapt_test.sv ====
/* self-checking bench for the odd nibble adapter.
   assumes idle octets on o_oct carry no payload and are skipped. */
`timescale 1ns/100ps
`default_nettype none
module sgmii_odd_nibble_tx_adapt_test;
	import nib_adapt_pkg::*;
	// ********************
	// clock, reset, monitor
	// ********************
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	nib_s mac_nib;
	logic o_valid;
	logic o_gap_short;
	oct_s o_oct;
	oct_s got[$];
	int failures = 0;
	int samples_checked = 0;
	int shorts = 0;
	always #5 i_clock = ~i_clock;
	mac_nib_model mac_u (.i_clock(i_clock), .o_nib(mac_nib));
	sgmii_odd_nibble_tx_adapt #(.GAP_CNT_W(8)) dut_u (.i_clock(i_clock),
		.i_rst(i_rst), .i_nib(mac_nib), .o_valid(o_valid), .o_oct(o_oct),
		.o_gap_short(o_gap_short));
	always @(negedge i_clock) begin
		if (o_valid === 1'b1 && (o_oct.en | o_oct.er)) got.push_back(o_oct);
		if (o_gap_short === 1'b1) shorts++;
	end
	// ********************
	// helpers
	// ********************
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic nibs(input int n, input logic en, input logic er,
		input logic [3:0] d);
		repeat (n) mac_u.put(en, er, d);
	endtask : nibs
	task automatic dat(input logic [3:0] a, input logic [3:0] b);
		nibs(1, 1'b1, 1'b0, a);
		nibs(1, 1'b1, 1'b0, b);
	endtask : dat
	task automatic expect_q(input int n, input logic [9:0] a, b, c, d);
		logic [9:0] e[4];
		e = '{a, b, c, d};
		nibs(6, 1'b0, 1'b0, 4'h0);
		chk(10'(got.size()), 10'(n));
		for (int i = 0; i < n && i < got.size(); i++) chk(got[i], e[i]);
		got.delete();
	endtask : expect_q
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	// ********************
	// scenarios
	// ********************
	task automatic s_pair;
		dat(4'hA, 4'hB);
		expect_q(1, 10'h2BA, 10'h0, 10'h0, 10'h0);
	endtask : s_pair
	task automatic s_odd_frame;
		dat(4'hA, 4'hB);
		nibs(1, 1'b1, 1'b0, 4'hC);
		expect_q(1, 10'h2BA, 10'h0, 10'h0, 10'h0);
	endtask : s_odd_frame
	task automatic s_err_nib;
		nibs(1, 1'b1, 1'b1, 4'hA);
		nibs(1, 1'b1, 1'b0, 4'hB);
		expect_q(1, 10'h3BA, 10'h0, 10'h0, 10'h0);
	endtask : s_err_nib
	task automatic s_odd_ext;
		dat(4'h1, 4'h2);
		nibs(3, 1'b0, 1'b1, 4'hF);
		dat(4'h3, 4'h4);
		expect_q(4, 10'h221, 10'h10F, 10'h11F, 10'h243);
	endtask : s_odd_ext
	task automatic s_one_ext;
		dat(4'h1, 4'h2);
		nibs(1, 1'b0, 1'b1, 4'hF);
		dat(4'h3, 4'h4);
		nibs(4, 1'b0, 1'b0, 4'h0);
		dat(4'h5, 4'h6);
		expect_q(4, 10'h221, 10'h11F, 10'h243, 10'h265);
	endtask : s_one_ext
	task automatic s_gap;
		dat(4'h1, 4'h2);
		nibs(3, 1'b0, 1'b0, 4'h0);
		dat(4'h3, 4'h4);
		nibs(4, 1'b0, 1'b0, 4'h0);
		dat(4'h5, 4'h6);
		expect_q(3, 10'h221, 10'h243, 10'h265, 10'h0);
		chk(10'(shorts), 10'h001);
	endtask : s_gap
	task automatic s_reset;
		dat(4'h7, 4'h8);
		nibs(1, 1'b1, 1'b0, 4'h9);
		nibs(1, 1'b0, 1'b0, 4'h0);
		i_rst = 1'b1;
		nibs(1, 1'b0, 1'b0, 4'h0);
		nibs(1, 1'b1, 1'b0, 4'h1);
		chk(10'(o_valid), 10'h000);
		chk(o_oct, 10'h000);
		i_rst = 1'b0;
		nibs(1, 1'b1, 1'b0, 4'h2);
		expect_q(2, 10'h287, 10'h221, 10'h0, 10'h0);
		chk(10'(shorts), 10'h001);
	endtask : s_reset
	initial begin
		repeat (3) @(posedge i_clock);
		#1 i_rst = 1'b0;
		s_pair();
		s_odd_frame();
		s_err_nib();
		s_odd_ext();
		s_one_ext();
		s_gap();
		s_reset();
		end_sim();
	end
endmodule : sgmii_odd_nibble_tx_adapt_test
`default_nettype wire
